// [hsync_edge_defs.svh]
// Constants for the horizontal sync edge select and clamp timing block.
// Assumes a single pixel-domain clock; no software-visible registers.
//
// Behaviour
// - Polarity bit picks falling or rising lead
// - Only leading edge reaches pixel clock generator
// - Trailing edge only starts internal clamp timing
// - Sync input is timing and frequency reference
// - Green comparator result driven out uninverted
// - Internal clamp counts delay, duration from trailing
// - External clamp pin used, sense per polarity
`ifndef HSYNC_EDGE_DEFS_SVH
`define HSYNC_EDGE_DEFS_SVH

// ==========================================================
// Field values and reset values
// ==========================================================
`define HS_POL_FALLING    1'h0   // Leading edge is falling
`define HS_POL_RISING     1'h1   // Leading edge is rising
`define CLAMP_DELAY_RST   8'h04  // Default clamp start delay, pixel clocks
`define CLAMP_WIDTH_RST   8'h14  // Default clamp duration, pixel clocks

`endif

// [hsync_edge_pkg.sv]
// Types shared by the sync edge select block.
// Assumes nothing beyond a SystemVerilog elaborator.
package hsync_edge_pkg;
    // Internal clamp sequencer states
    typedef enum logic [1:0] {
        CLAMP_IDLE,
        CLAMP_WAIT,
        CLAMP_HOLD
    } clamp_state_t;
endpackage

// [hsync_edge_select_routing.sv]
// Sync input handling: edge selection, pulse generation, clamp timing.
// Assumes sync inputs are synchronous-safe after the two-stage sampler
// and configuration inputs are quasi-static.
`timescale 1ns/10ps
`include "hsync_edge_defs.svh"

module hsync_edge_select_routing #(
    parameter int CNT_W = 8                  // Width of clamp delay and duration counts
) (
    input  wire logic             mclk,                 // Pixel domain clock, 25 MHz
    input  wire logic             rstn,                 // Synchronous reset, active low
    input  wire logic             horiz_sync_in_a,      // Horizontal sync input, channel 0
    input  wire logic             horiz_sync_in_b,      // Horizontal sync input, channel 1
    input  wire logic             syncSel,              // Channel select, 1 picks channel 1
    input  wire logic             hsync_edge_polarity,  // 0 falling lead, 1 rising lead
    input  wire logic             green_sync_in_a,      // Green comparator result, channel 0
    input  wire logic             green_sync_in_b,      // Green comparator result, channel 1
    input  wire logic             extClampEn,           // 1 uses external clamp pin
    input  wire logic             clampPol,             // 1 external clamp active high
    input  wire logic             clampPin,             // External clamp input
    input  wire logic [CNT_W-1:0] clampDelay,           // Cycles from trailing edge to clamp
    input  wire logic [CNT_W-1:0] clampWidth,           // Clamp duration in cycles
    output logic                  leadPulse,            // One-cycle leading edge pulse
    output logic                  trailPulse,           // One-cycle trailing edge pulse
    output logic                  pllRef,               // Reference strobe to clock generator
    output logic                  green_sync_out,       // Green sync output, not inverted
    output logic                  clampOut              // Clamp active, high
);

    // Elaboration check: counts need at least two bits
    if (CNT_W < 2) begin : g_chk
        $error("CNT_W too small");
    end

    // ==========================================================
    // Input sampling
    // ==========================================================
    logic       syncIn;         // Selected sync channel, before sampling
    logic       syncMeta_r;     // First sampler stage, read only by second
    logic       syncSamp_r;     // Second sampler stage
    logic       syncPrev_r;     // Previous sample for edge detect
    logic       greenMeta_r;    // Green path first stage
    logic       greenSamp_r;    // Green path second stage
    logic       clampMeta_r;    // Clamp pin first stage
    logic       clampSamp_r;    // Clamp pin second stage
    logic       syncAct;        // Sync after polarity, high in pulse

    // Channel select feeds the sync sampler
    assign syncIn = syncSel ? horiz_sync_in_b : horiz_sync_in_a;

    // Two-stage sampler on every external level
    // In reset the sync stages follow the live level: a line that idles high
    // would otherwise look like an edge, and start a clamp, after release
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            syncMeta_r  <= syncIn;
            syncSamp_r  <= syncIn;
            syncPrev_r  <= syncIn;
            greenMeta_r <= 1'h0;
            greenSamp_r <= 1'h0;
            clampMeta_r <= 1'h0;
            clampSamp_r <= 1'h0;
        end else begin
            syncMeta_r  <= syncIn;
            syncSamp_r  <= syncMeta_r;
            syncPrev_r  <= syncSamp_r;
            greenMeta_r <= syncSel ? green_sync_in_b : green_sync_in_a;
            greenSamp_r <= greenMeta_r;
            clampMeta_r <= clampPin;
            clampSamp_r <= clampMeta_r;
        end
    end

    // Polarity fold: active level is the one entered at the leading edge
    assign syncAct = (hsync_edge_polarity == `HS_POL_RISING) ? syncSamp_r : ~syncSamp_r;

    // ==========================================================
    // Edge pulses
    // ==========================================================
    logic actPrev;              // Previous folded level
    assign actPrev = (hsync_edge_polarity == `HS_POL_RISING) ? syncPrev_r : ~syncPrev_r;

    // Pulses are registered so downstream timing sees clean strobes
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            leadPulse  <= 1'h0;
            trailPulse <= 1'h0;
        end else begin
            leadPulse  <= syncAct & ~actPrev;
            trailPulse <= ~syncAct & actPrev;
        end
    end

    // Pulse checks use the polarity in force when the pulse was made,
    // since the polarity may be changed on any cycle
    AST_LEAD_POL: assert property (@(posedge mclk) disable iff (!rstn)
        leadPulse |-> ($past(syncSamp_r) == $past(hsync_edge_polarity))
            && ($past(syncPrev_r) != $past(hsync_edge_polarity)))
        else $error("Leading pulse on wrong edge");

    AST_TRAIL_POL: assert property (@(posedge mclk) disable iff (!rstn)
        trailPulse |-> ($past(syncSamp_r) != $past(hsync_edge_polarity))
            && ($past(syncPrev_r) == $past(hsync_edge_polarity)))
        else $error("Trailing pulse on wrong edge");

    AST_PULSE_ONE: assert property (@(posedge mclk) disable iff (!rstn)
        leadPulse |=> !leadPulse)
        else $error("Leading pulse longer than one cycle");

    // Only the leading edge is a reference; the trailing edge never reaches it
    assign pllRef = leadPulse;

    // Reference strobe is checked against the raw samples; its source check uses the fold
    AST_REF_LEAD: assert property (@(posedge mclk) disable iff (!rstn)
        pllRef |-> !trailPulse && ($past(syncSamp_r) != $past(syncPrev_r))
            && ($past(syncSamp_r) == $past(hsync_edge_polarity)))
        else $error("Reference strobe not from leading edge");

    AST_REF_SRC: assert property (@(posedge mclk) disable iff (!rstn)
        (syncAct && !actPrev) |=> pllRef)
        else $error("Sync lead did not reach reference");

    // ==========================================================
    // Green sync routing
    // ==========================================================
    // Registered, same sense as the comparator
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            green_sync_out <= 1'h0;
        end else begin
            green_sync_out <= greenSamp_r;
        end
    end

    // Output must follow the sampled comparator level, never its inverse
    AST_GREEN: assert property (@(posedge mclk) disable iff (!rstn)
        ##1 (green_sync_out == $past(greenSamp_r)))
        else $error("Green sync output inverted or stale");

    // ==========================================================
    // Internal clamp sequencer
    // ==========================================================
    hsync_edge_pkg::clamp_state_t clampSt_r;   // Sequencer state
    logic [CNT_W-1:0]             clampCnt_r;  // Down counter
    logic                         intClamp;    // Internal clamp window

    // Restarts on each trailing edge; a new edge aborts a window in progress
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            clampSt_r  <= hsync_edge_pkg::CLAMP_IDLE;
            clampCnt_r <= '0;
        end else if (trailPulse) begin
            if (clampDelay == '0) begin
                clampSt_r  <= hsync_edge_pkg::CLAMP_HOLD;
                clampCnt_r <= clampWidth;
            end else begin
                clampSt_r  <= hsync_edge_pkg::CLAMP_WAIT;
                clampCnt_r <= clampDelay;
            end
        end else begin
            unique case (clampSt_r)
                hsync_edge_pkg::CLAMP_IDLE: begin
                    clampCnt_r <= '0;
                end
                hsync_edge_pkg::CLAMP_WAIT: begin
                    // Count the delay, then open the window
                    if (clampCnt_r <= CNT_W'(1)) begin
                        clampSt_r  <= hsync_edge_pkg::CLAMP_HOLD;
                        clampCnt_r <= clampWidth;
                    end else begin
                        clampCnt_r <= clampCnt_r - CNT_W'(1);
                    end
                end
                hsync_edge_pkg::CLAMP_HOLD: begin
                    // Zero width closes the window at once
                    if (clampCnt_r <= CNT_W'(1)) begin
                        clampSt_r  <= hsync_edge_pkg::CLAMP_IDLE;
                        clampCnt_r <= '0;
                    end else begin
                        clampCnt_r <= clampCnt_r - CNT_W'(1);
                    end
                end
                default: begin
                    clampSt_r  <= hsync_edge_pkg::CLAMP_IDLE;
                    clampCnt_r <= '0;
                end
            endcase
        end
    end

    assign intClamp = (clampSt_r == hsync_edge_pkg::CLAMP_HOLD) && (clampCnt_r != '0);

    // Sequencer checks: a delay only ever starts from a trailing edge,
    // and every window opens with the full programmed duration
    AST_CLAMP_START: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(clampSt_r == hsync_edge_pkg::CLAMP_WAIT) |-> $past(trailPulse))
        else $error("Clamp delay started without trailing edge");

    AST_WIN_LEN: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(intClamp) |-> (clampCnt_r == $past(clampWidth)))
        else $error("Clamp window opened with wrong duration");

    // ==========================================================
    // Clamp source select
    // ==========================================================
    // External pin wins when enabled; its sense follows clampPol
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            clampOut <= 1'h0;
        end else if (extClampEn) begin
            clampOut <= clampPol ? clampSamp_r : ~clampSamp_r;
        end else begin
            clampOut <= intClamp;
        end
    end

    // Source checks look at the select that was in force one cycle back;
    // the cycle right after release still holds the reset value
    AST_CLAMP_INT: assert property (@(posedge mclk) disable iff (!rstn)
        (!extClampEn && !$past(extClampEn)) |-> (clampOut == $past(intClamp)))
        else $error("Internal clamp not used");

    AST_CLAMP_EXT: assert property (@(posedge mclk) disable iff (!rstn)
        ($past(rstn) && $past(extClampEn))
            |-> (clampOut == ($past(clampSamp_r) ~^ $past(clampPol))))
        else $error("External clamp sense wrong");

endmodule // hsync_edge_select_routing

// [sync_source_model.sv]
// Behavioural graphics source: two sync channels and two green levels.
// Assumes the bench sets line length, pulse width and idle level.
`timescale 1ns/10ps

module sync_source_model (
    input  wire logic       mclk,    // Pixel clock
    input  wire logic [7:0] period,  // Line length in cycles
    input  wire logic [7:0] width,   // Sync pulse width in cycles
    input  wire logic       idleHi,  // Idle level of both sync lines
    output logic            hsA,     // Sync, channel a
    output logic            hsB,     // Sync, channel b
    output logic            greenA,  // Comparator level, channel a
    output logic            greenB   // Comparator level, channel b
);
    logic [7:0] cnt_r;  // Position within the line
    logic [7:0] half;   // Start of channel b pulse
    initial cnt_r = 8'h00;
    // ==========================================================
    // Line counter, moves just after the edge like a real source
    always @(posedge mclk) begin
        cnt_r <= #2 (cnt_r + 8'h01 >= period) ? 8'h00 : cnt_r + 8'h01;
    end
    assign half   = period >> 1;
    // Channel b is offset by half a line so the select is really tested
    assign hsA    = idleHi ^ (cnt_r < width);
    assign hsB    = idleHi ^ (cnt_r >= half && cnt_r < half + width);
    assign greenA = cnt_r[1] ^ hsA;
    assign greenB = cnt_r[2];
endmodule // sync_source_model

// [tb_top.sv]
// Self-checking bench for the sync edge select block.
// Assumes the source model and a fixed-seed xorshift for stimulus.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end

module tb_top;
    logic mclk, rstn, syncSel, pol, extClampEn, clampPol, clampPin, idleHi;
    logic hsA, hsB, greenA, greenB, leadPulse, trailPulse, pllRef, greenOut, clampOut;
    logic [7:0] clampDelay, clampWidth, period, width;
    logic [31:0] seed, r;          // Generator state, config draw
    logic [3:0] xh, gh, ph;        // Sampled history, newest in bit 0
    logic expLead, expTrail, expClamp;
    int bad_count, samples_checked, ec, trEdge, skip;

    function automatic logic [31:0] xs32(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    hsync_edge_select_routing #(.CNT_W(8)) u_dut (.mclk(mclk), .rstn(rstn),
        .horiz_sync_in_a(hsA), .horiz_sync_in_b(hsB), .syncSel(syncSel),
        .hsync_edge_polarity(pol), .green_sync_in_a(greenA), .green_sync_in_b(greenB),
        .extClampEn(extClampEn), .clampPol(clampPol), .clampPin(clampPin),
        .clampDelay(clampDelay), .clampWidth(clampWidth), .leadPulse(leadPulse),
        .trailPulse(trailPulse), .pllRef(pllRef), .green_sync_out(greenOut),
        .clampOut(clampOut));
    sync_source_model u_src (.mclk(mclk), .period(period), .width(width),
        .idleHi(idleHi), .hsA(hsA), .hsB(hsB), .greenA(greenA), .greenB(greenB));

    // ==========================================================
    // Clock, random clamp pin
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        seed = xs32(seed);
        clampPin <= #2 seed[7];
    end

    // ==========================================================
    // Reference model: sampler, edge detect, clamp window
    always @(posedge mclk) begin
        // The sampler follows the live level in reset, so release shows no edge
        xh = rstn ? {xh[2:0], (syncSel ? hsB : hsA)} : {4{(syncSel ? hsB : hsA)}};
        gh = {gh[2:0], syncSel ? greenB : greenA};
        ph = {ph[2:0], clampPin};
        ec++;
        expLead  = pol ? (xh[2] & ~xh[3]) : (~xh[2] & xh[3]);
        expTrail = pol ? (~xh[2] & xh[3]) : (xh[2] & ~xh[3]);
        if (expTrail) trEdge = ec;
        expClamp = extClampEn ? (ph[2] ~^ clampPol) : (clampWidth != 8'h00 &&
            ec >= trEdge + clampDelay + 2 && ec <= trEdge + clampDelay + clampWidth + 1);
        #1;
        // Outputs lag three edges, so history is unreliable right after reset
        if (!rstn) skip = 4;
        else if (skip > 0) skip--;
        else begin
            `CHK("leadPulse", expLead, leadPulse)
            `CHK("pllRef", expLead, pllRef)
            `CHK("trailPulse", expTrail, trailPulse)
            `CHK("green_sync_out", gh[2], greenOut)
            `CHK("clampOut", expClamp, clampOut)
        end
    end

    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Sixteen tests of about 182 cycles each, plus reset and a margin
    initial begin
        repeat (16 * 182 + 600) @(posedge mclk);
        bad_count++;
        report_and_stop();
    end

    // ==========================================================
    // Main sequence: every mode combination, corner widths first
    initial begin
        {rstn, syncSel, pol, extClampEn, clampPol, idleHi} = 6'h0;
        {clampDelay, clampWidth, xh, gh, ph} = 28'h0;
        {period, width} = {8'h14, 8'h03};
        seed = 32'hc8b564b6;
        {bad_count, samples_checked, ec, skip, trEdge} = {32'h0, 32'h0, 32'h0, 32'h0, -32'sd1000};
        repeat (4) @(posedge mclk);
        #1;
        `CHK("reset outputs", 5'h00, {leadPulse, trailPulse, pllRef, greenOut, clampOut})
        #1 rstn = 1'h1;
        for (int t = 0; t < 16; t++) begin
            @(negedge mclk) r = seed;
            @(posedge mclk) #2;
            {extClampEn, pol, syncSel, clampPol} = t[3:0];
            idleHi = r[20];
            clampDelay = (t < 2) ? 8'h00 : {5'h0, r[2:0]};
            clampWidth = (t < 3) ? t[7:0] : {5'h0, r[5:3]};
            // Line stays longer than any clamp window so restarts never overlap
            period = 8'h14 + {2'h0, r[13:8]} % 8'h28;
            width = (t == 0) ? 8'h01 : 8'h01 + r[31:24] % (period - 8'h01);
            trEdge = -1000;
            skip = 20;
            repeat (180) @(posedge mclk);
            $display("test %0d done", t);
        end
        report_and_stop();
    end
endmodule // tb_top
